// ===== rtl/i2c_target_defines.svh
/*
  constants of the two-wire target port: framing counts, address widths,
  reset values. assumes nothing beyond being included once per file.
*/
`ifndef I2C_TARGET_DEFINES_SVH
`define I2C_TARGET_DEFINES_SVH
`define BYTE_BITS      4'd8
`define ACK_SLOT       4'd8
`define SLOT_END       4'd9
`define DEV_ADDR_W     7
`define REG_ADDR_W     16
`define REG_ADDR_RESET 16'h0000
`define DEV_ADDR_DFLT  7'h2a
`endif

// ===== rtl/i2c_target_pkg.sv
/*
  types of the two-wire target port.
  assumes i2c_target_defines.svh is on the include path.
*/
`include "i2c_target_defines.svh"
package i2c_target_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_DEVADDR, ST_ADDR_HI, ST_ADDR_LO, ST_WDATA, ST_RDATA
  } phase_e;

  typedef struct packed {
    logic                   wr;
    logic [`REG_ADDR_W-1:0] addr;
    logic [7:0]             data;
  } reg_wr_s;

  typedef struct packed {
    logic start;
    logic stop;
    logic rise;
    logic fall;
    logic sda;
  } line_ev_s;
endpackage

// ===== rtl/i2c_line_sync.sv
/*
  two-stage synchronisers for the serial clock and data pins, and detection
  of clock edges, start and stop. assumes pins idle high (pulled up).
*/
`timescale 1ns/1ps
module i2c_line_sync
  import i2c_target_pkg::*;
(
  input  wire logic clk_sys,   // system clock
  input  wire logic reset,     // async reset, active high
  input  wire logic scl_in,    // serial clock pin level
  input  wire logic sda_in,    // serial data pin level
  output line_ev_s  ev         // synchronised level and events
);
  logic [1:0] scl_meta;
  logic [1:0] sda_meta;
  logic       scl_q;
  logic       sda_q;

  // first stage feeds only the second
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      scl_meta <= 2'h3;
      sda_meta <= 2'h3;
    end
    else
    begin
      scl_meta <= {scl_meta[0], scl_in};
      sda_meta <= {sda_meta[0], sda_in};
    end
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= scl_meta[1];
      sda_q <= sda_meta[1];
    end
  end

  always_comb
  begin
    ev.sda   = sda_meta[1];
    ev.rise  = scl_meta[1] & ~scl_q;
    ev.fall  = ~scl_meta[1] & scl_q;
    ev.start = scl_meta[1] & scl_q & sda_q & ~sda_meta[1];
    ev.stop  = scl_meta[1] & scl_q & ~sda_q & sda_meta[1];
  end
endmodule

// ===== rtl/i2c_shift_reg.sv
/*
  eight-bit shift register with bit counter: samples on clock rise,
  shifts on that same rise, msb first. assumes event strobes from the sync.
*/
`timescale 1ns/1ps
`include "i2c_target_defines.svh"
module i2c_shift_reg
  import i2c_target_pkg::*;
(
  input  wire logic       clk_sys,  // system clock
  input  wire logic       reset,    // async reset, active high
  input  wire logic       clear,    // restart byte framing
  input  wire logic       load,     // load byte to transmit
  input  wire logic [7:0] load_val, // byte to transmit
  input  wire logic       rise,     // scl rising strobe
  input  wire logic       fall,     // scl falling strobe
  input  wire logic       sda,      // sampled data level
  output logic      [7:0] shreg,    // shift contents
  output logic      [3:0] bitcnt    // rises seen in this slot, 0..9
);
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      shreg <= 8'h00;
    else if (load)
      shreg <= load_val;
    else if (rise && bitcnt < `BYTE_BITS)
      shreg <= {shreg[6:0], sda};
  end

  // 0..7 data bits, 8 waits for the acknowledge sample, 9 until the slot closes;
  // two counts are needed because both falls around the acknowledge look alike
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      bitcnt <= 4'h0;
    else if (clear)
      bitcnt <= 4'h0;
    else if (fall && bitcnt == `SLOT_END)
      bitcnt <= 4'h0;
    else if (rise && bitcnt < `SLOT_END)
      bitcnt <= bitcnt + 4'h1;
  end
endmodule

// ===== rtl/i2c_target_reg_access.sv
/*
  two-wire target port giving an external master read and write access to
  the device registers through a sixteen-bit address pointer.
  assumes the register array sits outside: it takes reg_wr and answers
  rd_data combinationally for rd_addr. pins are open drain with pull-ups.
*/
`timescale 1ns/1ps
`include "i2c_target_defines.svh"
module i2c_target_reg_access
  import i2c_target_pkg::*;
(
  input  wire logic                    clk_sys,   // 20 MHz system clock
  input  wire logic                    reset,     // async reset, active high
  input  wire logic [`DEV_ADDR_W-1:0]  dev_addr,  // own target address
  input  wire logic                    scl_in,    // serial clock pin
  input  wire logic                    sda_in,    // serial data pin level
  output logic                         sda_out,   // serial data drive value
  output logic                         sda_oe_n,  // low while pulling data low
  output reg_wr_s                      reg_wr,    // register write strobe
  output logic [`REG_ADDR_W-1:0]       rd_addr,   // register read address
  input  wire logic [7:0]              rd_data,   // register read data
  output logic                         busy       // a transfer is open: from start until stop, a foreign address or a master nack
);
  line_ev_s               ev;
  phase_e                 phase;
  logic [7:0]             shreg;
  logic [3:0]             bitcnt;
  logic [`REG_ADDR_W-1:0] ptr;
  logic [7:0]             addr_hi;
  logic                   drive_low;
  logic                   next_drive_low;
  logic                   load_tx;
  logic                   byte_done;
  logic                   ack_seen;
  logic                   master_ack;
  logic                   ack_open;
  logic                   ack_close;
  logic                   addr_match;
  logic                   read_req;
  logic                   send_next;
  logic [7:0]             rx_byte;
  logic                   next_ack_low;
  logic                   next_bit_low;

  i2c_line_sync u_sync (
    .clk_sys (clk_sys),
    .reset   (reset),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .ev      (ev)
  );

  // the first fall after the eighth bit opens the acknowledge slot,
  // the fall after the acknowledge sample closes it
  assign ack_open   = ev.fall && bitcnt == `ACK_SLOT;
  assign ack_close  = ev.fall && bitcnt == `SLOT_END;
  assign addr_match = shreg[7:1] == dev_addr;
  assign read_req   = phase == ST_DEVADDR && addr_match && shreg[0];
  // a read byte goes out after a matched read address or a master acknowledge
  assign send_next  = read_req || (phase == ST_RDATA && master_ack);
  assign load_tx    = ack_close && send_next;
  // byte as it stands once the eighth bit is sampled
  assign rx_byte    = {shreg[6:0], ev.sda};

  i2c_shift_reg u_shift (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .clear    (ev.start | ev.stop),
    .load     (load_tx),
    .load_val (rd_data),
    .rise     (ev.rise),
    .fall     (ev.fall),
    .sda      (ev.sda),
    .shreg    (shreg),
    .bitcnt   (bitcnt)
  );

  // eighth data bit sampled: byte is complete
  assign byte_done = ev.rise && bitcnt == 4'h7;
  // master's answer sampled in the acknowledge slot of a read byte
  assign ack_seen  = ev.rise && bitcnt == `ACK_SLOT && phase == ST_RDATA;
  assign rd_addr   = ptr;
  assign busy      = phase != ST_IDLE;

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      master_ack <= 1'b0;
    else if (ev.start || ev.stop)
      master_ack <= 1'b0;
    else if (ack_seen)
      master_ack <= ~ev.sda;
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      phase <= ST_IDLE;
    else if (ev.start)
      phase <= ST_DEVADDR;
    else if (ev.stop)
      phase <= ST_IDLE;
    else if (ack_close)
    begin
      unique case (phase)
        ST_IDLE:    phase <= ST_IDLE;
        ST_DEVADDR:
        begin
          if (!addr_match)
            phase <= ST_IDLE;
          else if (shreg[0])
            phase <= ST_RDATA;
          else
            phase <= ST_ADDR_HI;
        end
        ST_ADDR_HI: phase <= ST_ADDR_LO;
        ST_ADDR_LO: phase <= ST_WDATA;
        ST_WDATA:   phase <= ST_WDATA;
        ST_RDATA:   phase <= master_ack ? ST_RDATA : ST_IDLE;
      endcase
    end
  end

  // high address byte waits here until the low byte completes the pointer
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      addr_hi <= 8'h00;
    else if (byte_done && phase == ST_ADDR_HI)
      addr_hi <= rx_byte;
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      ptr <= `REG_ADDR_RESET;
    else if (byte_done && phase == ST_ADDR_LO)
      ptr <= {addr_hi, rx_byte};
    else if (byte_done && phase == ST_WDATA)
      ptr <= ptr + 16'h0001;
    else if (ack_seen)
      ptr <= ptr + 16'h0001;
  end

  // one-cycle strobe; address and data hold until the next write
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      reg_wr <= '0;
    else if (byte_done && phase == ST_WDATA)
    begin
      reg_wr.wr   <= 1'b1;
      reg_wr.addr <= ptr;
      reg_wr.data <= rx_byte;
    end
    else
      reg_wr.wr <= 1'b0;
  end

  // acknowledge decision, applied at the fall that opens the slot
  always_comb
  begin
    next_ack_low = 1'b0;
    unique case (phase)
      ST_DEVADDR:                       next_ack_low = addr_match;
      ST_ADDR_HI, ST_ADDR_LO, ST_WDATA: next_ack_low = 1'b1;
      default:                          next_ack_low = 1'b0;
    endcase
  end

  // the first bit of a read byte comes straight from rd_data because the shift
  // register loads on that same fall; later bits have shifted up to the top
  always_comb
  begin
    next_bit_low = 1'b0;
    if (bitcnt == `SLOT_END)
      next_bit_low = send_next && ~rd_data[7];
    else if (phase == ST_RDATA && bitcnt != 4'h0 && bitcnt < `BYTE_BITS)
      next_bit_low = ~shreg[7];
  end

  // drive decisions taken on clock fall, so data only moves while low
  always_comb
  begin
    next_drive_low = drive_low;
    if (ev.start || ev.stop)
      next_drive_low = 1'b0;
    else if (ack_open)
      next_drive_low = next_ack_low;
    else if (ev.fall)
      next_drive_low = next_bit_low;
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      drive_low <= 1'b0;
    else
      drive_low <= next_drive_low;
  end

  // open drain: output value low, enable low only while pulling down; scl never driven
  assign sda_out  = 1'b0;
  assign sda_oe_n = ~drive_low;
endmodule

// ===== bench/i2c_target_monitor.sv
/* assertions on the target port pins and write strobe.
   assumes it is bound onto i2c_target_reg_access. */
`timescale 1ns/1ps
module i2c_target_monitor
  import i2c_target_pkg::*;
(
  input wire logic        clk_sys,  // clock
  input wire logic        reset,    // reset
  input wire logic [6:0]  dev_addr, // own address
  input wire logic        scl_in,   // clock pin
  input wire logic        sda_in,   // data pin
  input wire logic        sda_out,  // drive value
  input wire logic        sda_oe_n, // drive enable
  input wire reg_wr_s     reg_wr,   // write strobe
  input wire logic [15:0] rd_addr,  // pointer
  input wire logic [7:0]  rd_data,  // read data
  input wire logic        busy      // transfer open
);
  logic [15:0] wa;
  always_ff @(posedge clk_sys or posedge reset)
    if (reset)
      wa <= 16'h0000;
    else if (reg_wr.wr)
      wa <= reg_wr.addr;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  property p_od; $changed(sda_oe_n) |-> !scl_in; endproperty
  a_od: assert property (p_od) else $error("drive moved with clock high");
  property p_rst; disable iff (1'b0) reset |-> sda_oe_n && !busy && !reg_wr.wr; endproperty
  a_rst: assert property (p_rst) else $error("active in reset");
  // a drive only changes at clock falls, so it lasts a whole period
  property p_hold; $fell(sda_oe_n) |=> !sda_oe_n [*6]; endproperty
  a_hold: assert property (p_hold) else $error("short drive");
  property p_idle; !busy [*2] |-> sda_oe_n; endproperty
  a_idle: assert property (p_idle) else $error("idle drive");
  property p_drv; !sda_oe_n |-> busy; endproperty
  a_drv: assert property (p_drv) else $error("drive after end");
  property p_pulse; reg_wr.wr |=> !reg_wr.wr; endproperty
  a_pulse: assert property (p_pulse) else $error("long strobe");
  property p_step; reg_wr.wr |=> ##[0:16] rd_addr == wa + 16'h0001; endproperty
  a_step: assert property (p_step) else $error("no pointer step");
  property p_keep; !busy [*3] |-> $stable(rd_addr); endproperty
  a_keep: assert property (p_keep) else $error("idle pointer moved");
  c_wr: cover property (reg_wr.wr);
  c_drv: cover property ($fell(sda_oe_n));
  c_ptr: cover property ($changed(rd_addr));
endmodule
bind i2c_target_reg_access i2c_target_monitor mon (.clk_sys, .reset, .dev_addr, .scl_in,
  .sda_in, .sda_out, .sda_oe_n, .reg_wr, .rd_addr, .rd_data, .busy);

// ===== bench/i2c_master_model.sv
/* two-wire bus master: 400 ns bit clock, low 5 and high 3 cycles.
   assumes sda is the resolved line with a pull-up. */
`timescale 1ns/1ps
module i2c_master_model
(
  input  wire logic clk_sys, // bench clock
  input  wire logic sda,     // line level
  output logic      scl,     // bit clock, idles high
  output logic      sda_low  // pulls data low
);
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // long low phase leaves the target time to release before the rise
  task automatic bitx(input logic b, output logic r);
    sda_low <= !b;
    w(4);
    scl <= 1'b1;
    w(1);
    r = sda;
    w(2);
    scl <= 1'b0;
    w(1);
  endtask
  task automatic start();
    sda_low <= 1'b0;
    w(4);
    scl <= 1'b1;
    w(2);
    sda_low <= 1'b1;
    w(2);
    scl <= 1'b0;
    w(1);
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    w(4);
    scl <= 1'b1;
    w(2);
    sda_low <= 1'b0;
    w(2);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitx(d[i], r);
    bitx(1'b1, r);
    ack = !r;
  endtask
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 0; i < 8; i++)
    begin
      bitx(1'b1, r);
      d = {d[6:0], r};
    end
    bitx(last, r);
  endtask
endmodule

// ===== bench/i2c_target_reg_access_tb.sv
/* bench: master model, register file and reference model.
   assumes a 20 MHz clock and a pulled-up data line. */
`timescale 1ns/1ps
module i2c_target_reg_access_tb
  import i2c_target_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b0;
  logic [6:0]  dev_addr = 7'h2a;
  logic        scl, sda, sda_low, sda_out, sda_oe_n, busy, ack;
  reg_wr_s     reg_wr;
  logic [15:0] rd_addr;
  logic [7:0]  regs [256];
  logic [7:0]  d;
  logic [24:0] wq [$];
  int          exp_mem [256];
  int          exp_ptr = 0;
  int          seed = 78577;
  int          error_cnt = 0;
  int          compares = 0;
  always #25 clk_sys = ~clk_sys;
  assign sda = (sda_low || !sda_oe_n && !sda_out) ? 1'b0 : 1'b1;
  i2c_master_model m (.clk_sys, .sda, .scl, .sda_low);
  i2c_target_reg_access uut (.clk_sys, .reset, .dev_addr, .scl_in(scl), .sda_in(sda),
    .sda_out, .sda_oe_n, .reg_wr, .rd_addr, .rd_data(regs[rd_addr[7:0]]), .busy);
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      error_cnt++;
      $display("wrong value %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic give_verdict();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk_sys)
    if (reg_wr.wr === 1'b1)
    begin
      regs[reg_wr.addr[7:0]] <= reg_wr.data;
      chk("write", reg_wr, wq.size() > 0 ? wq.pop_front() : 25'h0);
    end
  task automatic hdr(input logic [6:0] a, input logic rw, input logic e);
    m.start();
    m.wbyte({a, rw}, ack);
    chk("addr ack", ack, e);
  endtask
  task automatic setp(input logic [15:0] p);
    hdr(dev_addr, 1'b0, 1'b1);
    m.wbyte(p[15:8], ack);
    chk("hi ack", ack, 1'b1);
    m.wbyte(p[7:0], ack);
    chk("lo ack", ack, 1'b1);
    exp_ptr = p;
  endtask
  task automatic wr(input int n);
    for (int i = 0; i < n; i++)
    begin
      d = 8'($random(seed));
      wq.push_back({1'b1, exp_ptr[15:0], d});
      exp_mem[exp_ptr % 256] = d;
      m.wbyte(d, ack);
      chk("data ack", ack, 1'b1);
      exp_ptr = (exp_ptr + 1) % 65536;
    end
  endtask
  task automatic rd(input int n);
    for (int i = 0; i < n; i++)
    begin
      m.rbyte(i == n - 1, d);
      chk("rdata", d, exp_mem[exp_ptr % 256]);
      exp_ptr = (exp_ptr + 1) % 65536;
    end
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    give_verdict();
  end
  initial
  begin
    reset <= 1'b1;
    for (int i = 0; i < 256; i++)
    begin
      regs[i] = i ^ 8'h3c;
      exp_mem[i] = i ^ 8'h3c;
    end
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk("reset ptr", rd_addr, 16'h0000);
    hdr(dev_addr, 1'b1, 1'b1);
    rd(2);
    m.stop();
    $display("test read from reset pointer done");
    setp(16'hfffe);
    wr(3);
    m.stop();
    chk("ptr wrap", rd_addr, exp_ptr);
    $display("test write across wrap done");
    setp(16'($random(seed)));
    m.stop();
    chk("ptr load", rd_addr, exp_ptr);
    hdr(dev_addr, 1'b1, 1'b1);
    rd(3);
    m.stop();
    setp(16'($random(seed)));
    hdr(dev_addr, 1'b1, 1'b1);
    rd(2);
    m.stop();
    $display("test load and combined read done");
    hdr(dev_addr ^ 7'h01, 1'b0, 1'b0);
    m.wbyte(8'($random(seed)), ack);
    chk("foreign ack", ack, 1'b0);
    chk("foreign busy", busy, 1'b0);
    m.stop();
    setp(16'($random(seed)));
    repeat (4) m.bitx(1'b0, ack);
    m.stop();
    hdr(dev_addr, 1'b1, 1'b1);
    rd(1);
    m.stop();
    chk("writes left", wq.size(), 0);
    $display("test foreign address and abort done");
    give_verdict();
  end
endmodule
